/* File: src/pbc_mux.v */
/*
 * Alternate-function mux for port B (all pins) and port C pins 7..5.
 * Assumes pads are synchronised here (two flops) and peripherals sit on clk.
 */
// Operation
// - Async select 1, ext clock 0: PB7 detached, becomes oscillator output.
// - Same configuration: PB6 detached, feeds oscillator amplifier input.
// - Crystal pins ignore their direction, output and readback bits.
// - SPI slave forces SCK (PB5) input; master follows direction bit.
// - SPI master forces MISO (PB4) input; slave follows direction bit.
// - SPI slave forces MOSI (PB3) input; master follows direction bit.
// - SPI slave forces slave-select (PB2) input, active low.
// - Forced SPI inputs keep pull-up controlled by the port output bit.
// - Clock-out enable forces PB0 output carrying the system clock.
// - PC6 is external reset after power-on until cleared by control.
// - PC6 is pin-change source 14 only when reset function disabled.
// - Two-wire enable gives PC5 to the two-wire unit as clock.
// - Digital-input disable turns off a channel pin's digital input.
// - PB0..7 feed pin-change 0..7, PC5..7 feed 13..15; sources 8..12 read 0.
// - Direction override enable selects override value for output enable.
// - Without pull-up override, pull-up from direction, output, global disable.
// - Peripheral input taken before port synchronizer, after Schmitt trigger; here it comes after the two pad synchroniser flops.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_mux_defs.vh"
module pbc_mux #(
   parameter integer NPIN = 8
) (
   // Clock and reset
   input  wire            clk,
   input  wire            rst_n,
   input  wire            clk_en,
   // Port registers
   input  wire [NPIN-1:0] port_b_dir,
   input  wire [NPIN-1:0] port_b_out,
   input  wire [NPIN-1:0] port_c_dir,
   input  wire [NPIN-1:0] port_c_out,
   input  wire            global_pullup_disable,
   // Configuration bits
   input  wire            timer2_async_select,
   input  wire            external_clock_select,
   input  wire            spi_enable,
   input  wire            spi_master,
   input  wire            spi_mosi_out,
   input  wire            spi_miso_out,
   input  wire            spi_sck_out,
   input  wire            timer2_compare_out_a_en,
   input  wire            timer2_compare_out_a,
   input  wire            timer1_compare_out_a_en,
   input  wire            timer1_compare_out_a,
   input  wire            timer1_compare_out_b_en,
   input  wire            timer1_compare_out_b,
   input  wire            clock_out_enable,
   input  wire            sys_clk_level,
   input  wire            reset_fn_clear,
   input  wire            two_wire_enable,
   input  wire            two_wire_scl_low,
   input  wire [2:0]      digital_input_disable_c,
   // Pads
   input  wire [NPIN-1:0] pad_b_in,
   input  wire [NPIN-1:0] pad_c_in,
   output reg  [NPIN-1:0] pad_b_oe,
   output reg  [NPIN-1:0] pad_b_out,
   output reg  [NPIN-1:0] pad_b_pu,
   output reg  [2:0]      pad_c_oe,
   output reg  [2:0]      pad_c_out,
   output reg  [2:0]      pad_c_pu,
   // Peripheral side
   output reg  [NPIN-1:0] port_b_in,
   output reg  [2:0]      port_c_in,
   output reg  [NPIN-1:0] peri_b_di,
   output reg  [2:0]      peri_c_di,
   output reg  [15:0]     pin_change_irq_source,
   output reg             timer_osc_active,
   output reg             serial_slave_select,
   output reg             external_reset_pin,
   output reg             timer1_capture_in
);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   wire osc_mode  = timer2_async_select & ~external_clock_select;
   wire spi_slv   = spi_enable & ~spi_master;
   wire spi_mst   = spi_enable & spi_master;
   reg  rst_fn_q, rst_fn_d;

   // Reset function held from power-on until software clears it
   always @* begin
      rst_fn_d = rst_fn_q;
      if (reset_fn_clear)
         rst_fn_d = 1'b0;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rst_fn_q <= `PBC_RST_PIN_EN;
      else if (clk_en)
         rst_fn_q <= rst_fn_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Override vectors, one bit per pin
   reg [NPIN-1:0] b_dir_oen, b_ddov, b_pvoe, b_pvov, b_pu_oen, b_puov, b_dieoe, b_dieov;
   reg [2:0]      c_dir_oen, c_ddov, c_pvoe, c_pvov, c_pu_oen, c_puov, c_dieoe, c_dieov;
   always @* begin
      b_dir_oen = `PBC_ZERO8;
      b_ddov = `PBC_ZERO8;
      b_pvoe = `PBC_ZERO8;
      b_pvov = `PBC_ZERO8;
      b_pu_oen = `PBC_ZERO8;
      b_puov = `PBC_ZERO8;
      b_dieoe = `PBC_ZERO8;
      b_dieov = `PBC_ZERO8;
      // Clock output on PB0
      if (clock_out_enable) begin
         b_dir_oen[`PBC_B_CLK_OUT] = 1'b1;
         b_ddov[`PBC_B_CLK_OUT] = 1'b1;
         b_pvoe[`PBC_B_CLK_OUT] = 1'b1;
         b_pvov[`PBC_B_CLK_OUT] = sys_clk_level;
      end
      // Timer compares drive only once software set direction
      b_pvoe[`PBC_B_CMP1A] = timer1_compare_out_a_en;
      b_pvov[`PBC_B_CMP1A] = timer1_compare_out_a;
      b_pvoe[`PBC_B_SS]   = timer1_compare_out_b_en;
      b_pvov[`PBC_B_SS]   = timer1_compare_out_b;
      b_pvoe[`PBC_B_MOSI] = timer2_compare_out_a_en;
      b_pvov[`PBC_B_MOSI] = timer2_compare_out_a;
      // SPI: forced inputs leave pull-up to the joint control
      if (spi_slv) begin
         b_dir_oen[`PBC_B_SCK]  = 1'b1;
         b_dir_oen[`PBC_B_MOSI] = 1'b1;
         b_dir_oen[`PBC_B_SS]   = 1'b1;
         b_pvoe[`PBC_B_MISO] = 1'b1;
         b_pvov[`PBC_B_MISO] = spi_miso_out;
      end
      if (spi_mst) begin
         b_dir_oen[`PBC_B_MISO] = 1'b1;
         b_pvoe[`PBC_B_SCK]  = 1'b1;
         b_pvov[`PBC_B_SCK]  = spi_sck_out;
         if (!timer2_compare_out_a_en) begin
            b_pvoe[`PBC_B_MOSI] = 1'b1;
            b_pvov[`PBC_B_MOSI] = spi_mosi_out;
         end
      end
      // Crystal pins: everything forced off, last so it wins
      if (osc_mode) begin
         b_dir_oen[`PBC_B_OSC_OUT] = 1'b1;
         b_pu_oen[`PBC_B_OSC_OUT] = 1'b1;
         b_pvoe[`PBC_B_OSC_OUT] = 1'b1;
         b_dieoe[`PBC_B_OSC_OUT] = 1'b1;
         b_dir_oen[`PBC_B_OSC_IN] = 1'b1;
         b_pu_oen[`PBC_B_OSC_IN] = 1'b1;
         b_pvoe[`PBC_B_OSC_IN] = 1'b1;
         b_dieoe[`PBC_B_OSC_IN] = 1'b1;
      end
   end

   // Port C pins 7..5, index 0..2
   always @* begin
      c_dir_oen = 3'h0;
      c_ddov = 3'h0;
      c_pvoe = 3'h0;
      c_pvov = 3'h0;
      c_pu_oen = 3'h0;
      c_puov = 3'h0;
      c_dieoe = digital_input_disable_c;
      c_dieov = 3'h0;
      // Two-wire clock: open drain, pull low only
      if (two_wire_enable) begin
         c_dir_oen[`PBC_C_SCL-`PBC_C_LOW] = 1'b1;
         c_ddov[`PBC_C_SCL-`PBC_C_LOW] = two_wire_scl_low;
         c_pvoe[`PBC_C_SCL-`PBC_C_LOW] = 1'b1;
         c_pvov[`PBC_C_SCL-`PBC_C_LOW] = 1'b0;
      end
      // Reset pin: input with pull-up, no digital path to the port
      if (rst_fn_q) begin
         c_dir_oen[`PBC_C_RST-`PBC_C_LOW] = 1'b1;
         c_pu_oen[`PBC_C_RST-`PBC_C_LOW] = 1'b1;
         c_puov[`PBC_C_RST-`PBC_C_LOW] = 1'b1;
         c_dieoe[`PBC_C_RST-`PBC_C_LOW] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin cells
   // Synchroniser flops, declared here because the cells read them
   reg  [NPIN-1:0] b_sync1_q, b_sync2_q, c_sync1_q, c_sync2_q;
   wire [NPIN-1:0] b_oe, b_out, b_pu, b_di;
   wire [2:0]      c_oe, c_out, c_pu, c_di;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_b
         pbc_mux_pin u_pin (
            .dir_bit    (port_b_dir[gi]),
            .out_bit    (port_b_out[gi]),
            .pullup_off (global_pullup_disable),
            .dir_ov_en  (b_dir_oen[gi]),
            .dir_ov_val (b_ddov[gi]),
            .val_ov_en  (b_pvoe[gi]),
            .val_ov_val (b_pvov[gi]),
            .pu_ov_en   (b_pu_oen[gi]),
            .pu_ov_val  (b_puov[gi]),
            .die_ov_en  (b_dieoe[gi]),
            .die_ov_val (b_dieov[gi]),
            .pad_in     (b_sync2_q[gi]),
            .pad_oe     (b_oe[gi]),
            .pad_out    (b_out[gi]),
            .pad_pu     (b_pu[gi]),
            .di         (b_di[gi])
         );
      end
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_c
         pbc_mux_pin u_pin (
            .dir_bit    (port_c_dir[gi+`PBC_C_LOW]),
            .out_bit    (port_c_out[gi+`PBC_C_LOW]),
            .pullup_off (global_pullup_disable),
            .dir_ov_en  (c_dir_oen[gi]),
            .dir_ov_val (c_ddov[gi]),
            .val_ov_en  (c_pvoe[gi]),
            .val_ov_val (c_pvov[gi]),
            .pu_ov_en   (c_pu_oen[gi]),
            .pu_ov_val  (c_puov[gi]),
            .die_ov_en  (c_dieoe[gi]),
            .die_ov_val (c_dieov[gi]),
            .pad_in     (c_sync2_q[gi+`PBC_C_LOW]),
            .pad_oe     (c_oe[gi]),
            .pad_out    (c_out[gi]),
            .pad_pu     (c_pu[gi]),
            .di         (c_di[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pad synchronisers; pads are async to clk, so two flops come first.
   // The cell's di is thus two cycles late, the nearest a clocked model gets
   // to a tap ahead of the port synchronizer.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b_sync1_q <= `PBC_ZERO8;
         b_sync2_q <= `PBC_ZERO8;
         c_sync1_q <= `PBC_ZERO8;
         c_sync2_q <= `PBC_ZERO8;
      end else if (clk_en) begin
         b_sync1_q <= pad_b_in;
         b_sync2_q <= b_sync1_q;
         c_sync1_q <= pad_c_in;
         c_sync2_q <= c_sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_b_oe <= `PBC_ZERO8;
         pad_b_out <= `PBC_ZERO8;
         pad_b_pu <= `PBC_ZERO8;
         pad_c_oe <= 3'h0;
         pad_c_out <= 3'h0;
         pad_c_pu <= 3'h0;
         port_b_in <= `PBC_ZERO8;
         port_c_in <= 3'h0;
         peri_b_di <= `PBC_ZERO8;
         peri_c_di <= 3'h0;
         pin_change_irq_source <= 16'h0000;
         timer_osc_active <= 1'b0;
         serial_slave_select <= 1'b1;
         external_reset_pin <= 1'b1;
         timer1_capture_in <= 1'b0;
      end else if (clk_en) begin
         pad_b_oe <= b_oe;
         pad_b_out <= b_out;
         pad_b_pu <= b_pu;
         pad_c_oe <= c_oe;
         pad_c_out <= c_out;
         pad_c_pu <= c_pu;
         port_b_in <= b_di;
         port_c_in <= c_di;
         peri_b_di <= b_di;
         peri_c_di <= c_di;
         // Port C pins 4..0 are outside this block; their sources read 0
         pin_change_irq_source <= {c_di, 5'h00, b_di};
         timer_osc_active <= osc_mode;
         // Active low; idle high when not a slave
         serial_slave_select <= spi_slv ? b_sync2_q[`PBC_B_SS] : 1'b1;
         external_reset_pin <= rst_fn_q ? c_sync2_q[`PBC_C_RST] : 1'b1;
         timer1_capture_in <= b_di[`PBC_B_CLK_OUT];
      end
   end

endmodule // pbc_mux

`default_nettype wire

/* File: src/pbc_mux_defs.vh */
/*
 * Constants for the port B / port C alternate-function mux.
 * Assumes inclusion by bare name from design files under src/.
 */
`ifndef PBC_MUX_DEFS_VH
`define PBC_MUX_DEFS_VH

// Port B pin positions
`define PBC_B_CLK_OUT   0
`define PBC_B_CMP1A     1
`define PBC_B_SS        2
`define PBC_B_MOSI      3
`define PBC_B_MISO      4
`define PBC_B_SCK       5
`define PBC_B_OSC_IN    6
`define PBC_B_OSC_OUT   7
// Port C pin positions (only 7..5 are handled)
`define PBC_C_LOW       5
`define PBC_C_SCL       5
`define PBC_C_RST       6
`define PBC_C_ADC8      7
// Reset values
`define PBC_RST_PIN_EN  1'b1
`define PBC_ZERO8       8'h00

`endif

/* File: src/pbc_mux_pin.v */
/*
 * One pin's generic override cell: direction, value, pull-up, input enable.
 * Assumes the pad sits outside; di is taken after the two pad synchroniser flops in pbc_mux.
 */
`timescale 1ns/1ps
`default_nettype none

module pbc_mux_pin (
   // Port register bits
   input  wire dir_bit,
   input  wire out_bit,
   input  wire pullup_off,
   // Overrides
   input  wire dir_ov_en,
   input  wire dir_ov_val,
   input  wire val_ov_en,
   input  wire val_ov_val,
   input  wire pu_ov_en,
   input  wire pu_ov_val,
   input  wire die_ov_en,
   input  wire die_ov_val,
   // Pad side
   input  wire pad_in,
   output wire pad_oe,
   output wire pad_out,
   output wire pad_pu,
   output wire di
);

   // Direction from override or port register
   assign pad_oe  = dir_ov_en ? dir_ov_val : dir_bit;
   assign pad_out = (val_ov_en & pad_oe) ? val_ov_val : out_bit;
   // Pull-up: joint control unless overridden; output bit keeps pull-up on forced inputs
   assign pad_pu  = pu_ov_en ? pu_ov_val :
                    (~pad_oe & out_bit & ~pullup_off);
   // Raw digital input, gated only by input enable
   assign di      = (die_ov_en ? die_ov_val : 1'b1) & pad_in;

endmodule // pbc_mux_pin

`default_nettype wire

/* File: tb/pbc_mux_bench.sv */
/* Self-checking bench for pbc_mux with the pad model on its pins.
   Assumes 50 ns clock, pad outputs one cycle after inputs, pad inputs three. */
`timescale 1ns/1ps
`default_nettype none
module pbc_mux_bench;
   // Design inputs
   logic clk, rst_n, clk_en, global_pullup_disable, timer2_async_select;
   logic external_clock_select, spi_enable, spi_master, spi_mosi_out, spi_miso_out;
   logic spi_sck_out, timer2_compare_out_a_en, timer2_compare_out_a, sys_clk_level;
   logic timer1_compare_out_a_en, timer1_compare_out_a, timer1_compare_out_b_en;
   logic timer1_compare_out_b, clock_out_enable, reset_fn_clear, two_wire_enable;
   logic two_wire_scl_low;
   logic [7:0]  port_b_dir, port_b_out, port_c_dir, port_c_out, pad_b_in, pad_c_in;
   logic [2:0]  digital_input_disable_c;
   logic [15:0] ext_val, ext_en;
   // Design outputs
   logic [7:0]  pad_b_oe, pad_b_out, pad_b_pu, port_b_in, peri_b_di;
   logic [2:0]  pad_c_oe, pad_c_out, pad_c_pu, port_c_in, peri_c_di;
   logic [15:0] pin_change_irq_source;
   logic timer_osc_active, serial_slave_select, external_reset_pin, timer1_capture_in;
   logic [28:0] rows [8];
   int err_total, comparisons;
   pbc_mux u_dut (.*);
   pbc_pad_model u_pad (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Rows: {clk_out_en, ext_clk, async, master, spi_en}, dir, expected oe, expected pu
   initial begin
      {rst_n, clk_en, global_pullup_disable, timer2_async_select, external_clock_select,
       spi_enable, spi_master, spi_mosi_out, spi_miso_out, spi_sck_out, sys_clk_level,
       timer2_compare_out_a_en, timer2_compare_out_a, timer1_compare_out_a_en,
       timer1_compare_out_a, timer1_compare_out_b_en, timer1_compare_out_b,
       clock_out_enable, reset_fn_clear, two_wire_enable, two_wire_scl_low} = '0;
      {port_b_dir, port_c_dir, digital_input_disable_c, ext_val, ext_en} = '0;
      port_b_out = 8'hFF;
      port_c_out = 8'h40;
      err_total = 0;
      comparisons = 0;
      rows = '{{5'h00, 8'hFF, 8'hFF, 8'h00}, {5'h00, 8'h00, 8'h00, 8'hFF},
               {5'h04, 8'hFF, 8'h3F, 8'h00}, {5'h0C, 8'hFF, 8'hFF, 8'h00},
               {5'h01, 8'hFF, 8'hD3, 8'h2C}, {5'h03, 8'hFF, 8'hEF, 8'h10},
               {5'h10, 8'h00, 8'h01, 8'hFE}, {5'h17, 8'h00, 8'h01, 8'h3E}};
      clk_en = 1'b1;
      repeat (20) @(posedge clk);
      #5 rst_n = 1'b1;
      port_c_dir = 8'h40;
      for (int i = 0; i < 8; i++) begin
         {clock_out_enable, external_clock_select, timer2_async_select, spi_master,
          spi_enable} = rows[i][28:24];
         sys_clk_level = rows[i][28];
         port_b_dir = rows[i][23:16];
         cyc(2);
         chk(pad_b_oe, rows[i][15:8]);
         chk(pad_b_pu, rows[i][7:0]);
      end
      // Slave mode with pins driven from outside
      {clock_out_enable, external_clock_select, timer2_async_select, spi_master,
       spi_enable} = 5'h01;
      port_b_dir = 8'h00;
      ext_en = 16'hFFFF;
      ext_val = 16'h00A1;
      cyc(4);
      chk(pin_change_irq_source[7:0], 8'hA1);
      chk(peri_b_di, 8'hA1);
      chk(serial_slave_select, 1'b0);
      chk(timer1_capture_in, 1'b1);
      chk(external_reset_pin, 1'b0);
      // Crystal mode blanks the readback of the two crystal pins
      timer2_async_select = 1'b1;
      cyc(2);
      chk(port_b_in, 8'h21);
      chk(timer_osc_active, 1'b1);
      timer2_async_select = 1'b0;
      // Reset pin masks its pin change until released
      ext_val[15:13] = 3'h7;
      cyc(4);
      chk(pin_change_irq_source[15:8], 8'hA0);
      chk(pad_c_pu, 3'h2);
      reset_fn_clear = 1'b1;
      cyc(1);
      reset_fn_clear = 1'b0;
      cyc(4);
      chk(pin_change_irq_source[15:8], 8'hE0);
      chk(external_reset_pin, 1'b1);
      chk({pad_c_oe, pad_c_out}, 6'h12);
      digital_input_disable_c = 3'h5;
      cyc(4);
      chk(peri_c_di, 3'h2);
      chk(port_c_in, 3'h2);
      {two_wire_enable, two_wire_scl_low} = 2'b11;
      cyc(2);
      chk({pad_c_oe, pad_c_out}, 6'h1A);
      // Direction goes to output before any compare unit drives
      spi_enable = 1'b0;
      port_b_dir = 8'h0E;
      cyc(1);
      {timer2_compare_out_a_en, timer2_compare_out_a, timer1_compare_out_a_en,
       timer1_compare_out_a, timer1_compare_out_b_en, timer1_compare_out_b} = 6'h2A;
      cyc(2);
      chk({pad_b_oe[3:1], pad_b_out[3:1]}, 6'h38);
      // Frozen clock enable holds outputs
      clk_en = 1'b0;
      port_b_dir = 8'h00;
      cyc(2);
      chk(pad_b_oe, 8'h0E);
      clk_en = 1'b1;
      global_pullup_disable = 1'b1;
      cyc(2);
      chk(pad_b_pu, 8'h00);
      // Mid-run reset rearms the reset pin
      rst_n = 1'b0;
      #1;
      chk({pad_b_oe, serial_slave_select, external_reset_pin}, 10'h003);
      cyc(3);
      rst_n = 1'b1;
      ext_val[14] = 1'b0;
      cyc(5);
      chk(external_reset_pin, 1'b0);
      final_report();
   end
endmodule // pbc_mux_bench
`default_nettype wire

/* File: tb/pbc_mux_monitor.sv */
/* Concurrent checks on the pbc_mux pad override outputs.
   Assumes one clock domain, async active-low reset, bound onto pbc_mux. */
`timescale 1ns/1ps
`default_nettype none
module pbc_mux_monitor #(
   parameter integer NPIN = 8
) (
   // Clock and reset
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            clk_en,
   // Controls
   input wire logic [NPIN-1:0] port_b_dir,
   input wire logic [NPIN-1:0] port_b_out,
   input wire logic            global_pullup_disable,
   input wire logic            timer2_async_select,
   input wire logic            external_clock_select,
   input wire logic            spi_enable,
   input wire logic            spi_master,
   input wire logic            clock_out_enable,
   input wire logic            sys_clk_level,
   input wire logic            reset_fn_clear,
   input wire logic            two_wire_enable,
   input wire logic            two_wire_scl_low,
   // Watched outputs
   input wire logic [NPIN-1:0] pad_b_oe,
   input wire logic [NPIN-1:0] pad_b_out,
   input wire logic [NPIN-1:0] pad_b_pu,
   input wire logic [2:0]      pad_c_oe,
   input wire logic [2:0]      pad_c_out,
   input wire logic [2:0]      pad_c_pu,
   input wire logic            timer_osc_active
);
   logic live_q;
   logic armed_q;
   wire logic xtal = timer2_async_select & ~external_clock_select;
   wire logic slv  = spi_enable & ~spi_master;
   wire logic mst  = spi_enable & spi_master;
   ////////////////////////////////////////////////////////////////////////
   // Outputs still hold reset values at the first edge after release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_q  <= 1'b0;
         armed_q <= 1'b1;
      end else begin
         live_q <= 1'b1;
         if (clk_en && reset_fn_clear) begin
            armed_q <= 1'b0;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_XTAL_OUT: assert property (live_q && $past(clk_en && xtal)
      |-> !pad_b_oe[7] && !pad_b_pu[7]) else $error("Crystal out pin not released");
   AST_XTAL_IN: assert property (live_q && $past(clk_en && xtal)
      |-> !pad_b_oe[6] && !pad_b_pu[6]) else $error("Crystal in pin not released");
   AST_OSC_FLAG: assert property (live_q && $past(clk_en)
      |-> timer_osc_active == $past(xtal)) else $error("Oscillator flag wrong");
   AST_SCK_IN: assert property (live_q && $past(clk_en && slv) |-> !pad_b_oe[5])
      else $error("Slave clock pin driven");
   AST_MISO_IN: assert property (live_q && $past(clk_en && mst) |-> !pad_b_oe[4])
      else $error("Master data input driven");
   AST_MOSI_IN: assert property (live_q && $past(clk_en && slv) |-> !pad_b_oe[3])
      else $error("Slave data input driven");
   AST_SS_IN: assert property (live_q && $past(clk_en && slv) |-> !pad_b_oe[2])
      else $error("Slave select pin driven");
   AST_SPI_PU: assert property (live_q && $past(clk_en && slv)
      |-> pad_b_pu[5] == $past(port_b_out[5] & ~global_pullup_disable))
      else $error("Forced input pull-up wrong");
   AST_CLK_OUT: assert property (live_q && $past(clk_en && clock_out_enable)
      |-> pad_b_oe[0] && pad_b_out[0] == $past(sys_clk_level))
      else $error("Clock output not forced");
   AST_DIR_B1: assert property (live_q && $past(clk_en)
      |-> pad_b_oe[1] == $past(port_b_dir[1])) else $error("Direction not followed");
   AST_PU_B1: assert property (live_q && $past(clk_en)
      |-> pad_b_pu[1] == $past(~port_b_dir[1] & port_b_out[1] & ~global_pullup_disable))
      else $error("Joint pull-up wrong");
   AST_RST_PIN: assert property (live_q && armed_q && $past(armed_q)
      |-> !pad_c_oe[1] && pad_c_pu[1]) else $error("Reset pin not an input");
   AST_SCL_LOW: assert property (live_q
      && $past(clk_en && two_wire_enable && two_wire_scl_low)
      |-> pad_c_oe[0] && !pad_c_out[0]) else $error("Two-wire clock not pulled low");
endmodule // pbc_mux_monitor
bind pbc_mux pbc_mux_monitor #(.NPIN(NPIN)) u_mon (.clk, .rst_n, .clk_en, .port_b_dir,
   .port_b_out, .global_pullup_disable, .timer2_async_select, .external_clock_select,
   .spi_enable, .spi_master, .clock_out_enable, .sys_clk_level, .reset_fn_clear,
   .two_wire_enable, .two_wire_scl_low, .pad_b_oe, .pad_b_out, .pad_b_pu, .pad_c_oe,
   .pad_c_out, .pad_c_pu, .timer_osc_active);
`default_nettype wire

/* File: tb/pbc_pad_model.sv */
/* Pin-level model of external drivers and pads around pbc_mux.
   Assumes ext bits 7..0 are port B, 15..8 port C; no keeper on pads. */
`timescale 1ns/1ps
`default_nettype none
module pbc_pad_model (
   // Mux side
   input wire logic [7:0]  pad_b_oe,
   input wire logic [7:0]  pad_b_out,
   input wire logic [7:0]  pad_b_pu,
   input wire logic [2:0]  pad_c_oe,
   input wire logic [2:0]  pad_c_out,
   input wire logic [2:0]  pad_c_pu,
   // Outside drivers
   input wire logic [15:0] ext_val,
   input wire logic [15:0] ext_en,
   // Pad levels
   output logic     [7:0]  pad_b_in,
   output logic     [7:0]  pad_c_in
);
   ////////////////////////////////////////////////////////////////////////
   // Chip drive wins; a floating pin without pull-up reads inverted noise
   always_comb begin
      pad_b_in = (pad_b_oe & pad_b_out) | (~pad_b_oe & ext_en[7:0] & ext_val[7:0])
               | (~pad_b_oe & ~ext_en[7:0] & (pad_b_pu | ~ext_val[7:0]));
      pad_c_in[4:0] = ext_val[12:8];
      pad_c_in[7:5] = (pad_c_oe & pad_c_out) | (~pad_c_oe & ext_en[15:13] & ext_val[15:13])
                    | (~pad_c_oe & ~ext_en[15:13] & (pad_c_pu | ~ext_val[15:13]));
   end
endmodule // pbc_pad_model
`default_nettype wire
